/* src/fsbp_pkg.sv */
package fsbp_pkg;
    localparam int STAT_W = 8;
    localparam int BUSY_POS = 0;
    localparam int WEL_POS = 1;
    localparam int LVL_LO_POS = 2;
    localparam int LVL_HI_POS = 4;
    localparam int LOCK_POS = 7;
    localparam logic [2:0] LVL_RESET = 3'h7;
    localparam logic LOCK_RESET = 1'h0;
    localparam logic WEL_RESET = 1'h0;
    localparam int ADDR_W = 24;
    // block index is address bits 21..16
    localparam int BLK_LO = 16;
    localparam int BLK_HI = 21;
    localparam logic [2:0] LVL_NONE = 3'h0;
    localparam logic [2:0] LVL_ALL = 3'h7;
    // operation codes of the request port
    typedef enum logic [1:0] {
        FSBP_OP_PAGE = 2'h0,
        FSBP_OP_SECTOR = 2'h1,
        FSBP_OP_BLOCK = 2'h2,
        FSBP_OP_CHIP = 2'h3
    } fsbp_op_e;
    typedef enum logic [1:0] {
        FSBP_IDLE,
        FSBP_BUSY
    } fsbp_state_e;
endpackage

/* src/fsbp_status.sv */
`timescale 1ns/1ps
module fsbp_status
    import fsbp_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic I_WP_N,
    input wire logic i_write_enable_cmd,
    input wire logic i_write_disable_cmd,
    input wire logic i_status_write_cmd,
    input wire logic [STAT_W-1:0] i_status_wdata,
    input wire logic i_op_req,
    input wire logic [1:0] i_op_code,
    input wire logic [ADDR_W-1:0] i_op_addr,
    input wire logic i_op_done,
    output logic o_op_start,
    output logic o_op_refused,
    output logic [STAT_W-1:0] o_status
);
    logic wp1_r;
    logic wp2_r;
    logic wel_r;
    logic wel_nxt;
    logic [2:0] lvl_r;
    logic [2:0] lvl_nxt;
    logic lock_r;
    logic lock_nxt;
    fsbp_state_e state_r;
    fsbp_state_e state_nxt;
    logic start_r;
    logic refused_r;

    // pin is asynchronous; only the second stage feeds logic
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            wp1_r <= 1'h0;
            wp2_r <= 1'h0;
        end else begin
            wp1_r <= I_WP_N;
            wp2_r <= wp1_r;
        end
    end

    // state and operation decode
    logic is_idle;
    logic is_busy;
    logic is_page;
    logic is_sector;
    logic is_block;
    logic is_chip;
    logic is_ranged;
    assign is_idle = (state_r == FSBP_IDLE);
    assign is_busy = (state_r == FSBP_BUSY);
    assign is_page = (i_op_code == FSBP_OP_PAGE);
    assign is_sector = (i_op_code == FSBP_OP_SECTOR);
    assign is_block = (i_op_code == FSBP_OP_BLOCK);
    assign is_chip = (i_op_code == FSBP_OP_CHIP);
    // page program and sector or block erase aim at one block
    assign is_ranged = is_page || is_sector || is_block;

    // block index and lower bound of protected blocks
    logic [5:0] blk;
    logic [5:0] bound;
    assign blk = i_op_addr[BLK_HI:BLK_LO];
    always_comb begin
        case (lvl_r)
            3'h1: bound = 6'h3F;
            3'h2: bound = 6'h3E;
            3'h3: bound = 6'h3C;
            3'h4: bound = 6'h38;
            3'h5: bound = 6'h30;
            3'h6: bound = 6'h20;
            default: bound = 6'h00;
        endcase
    end

    // protection verdicts
    logic in_range;
    logic ranged_bad;
    logic chip_bad;
    logic op_ok;
    assign in_range = (lvl_r != LVL_NONE) && (blk >= bound);
    assign ranged_bad = is_ranged && in_range;
    assign chip_bad = is_chip && (lvl_r != LVL_NONE);
    assign op_ok = wel_r && !ranged_bad && !chip_bad;

    // command acceptance; while busy only the done pulse counts
    logic op_take;
    logic op_bad;
    logic sw_allowed;
    logic sw_take;
    logic sw_commit;
    logic dis_take;
    logic en_take;
    logic done_take;
    assign op_take = i_op_req && is_idle && op_ok;
    assign op_bad = i_op_req && is_idle && !op_ok;
    assign sw_allowed = wp2_r || !lock_r;
    // status write needs the latch and yields to a taken request
    assign sw_take = i_status_write_cmd && is_idle && wel_r && !op_take;
    assign sw_commit = sw_take && sw_allowed;
    assign dis_take = i_write_disable_cmd && is_idle && !op_take && !sw_take;
    assign en_take = i_write_enable_cmd && is_idle && !op_take && !sw_take && !i_write_disable_cmd;
    assign done_take = is_busy && i_op_done;

    // writable fields of the incoming status byte
    logic [2:0] lvl_wr;
    logic lock_wr;
    assign lvl_wr = i_status_wdata[LVL_HI_POS:LVL_LO_POS];
    assign lock_wr = i_status_wdata[LOCK_POS];

    // latch drops even when a locked status write changes nothing
    assign wel_nxt = (done_take || dis_take || sw_take) ? 1'h0 : (en_take ? 1'h1 : wel_r);
    // level and lock-down move only through a permitted status write
    assign lvl_nxt = sw_commit ? lvl_wr : lvl_r;
    assign lock_nxt = sw_commit ? lock_wr : lock_r;

    // idle until a request is taken, busy until the array reports done
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FSBP_IDLE: begin
                if (op_take) begin
                    state_nxt = FSBP_BUSY;
                end
            end
            FSBP_BUSY: begin
                if (i_op_done) begin
                    state_nxt = FSBP_IDLE;
                end
            end
            default: begin
                state_nxt = FSBP_IDLE;
            end
        endcase
    end

    // every status bit returns to its power-up value on reset
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            state_r <= FSBP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            wel_r <= WEL_RESET;
        end else begin
            wel_r <= wel_nxt;
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            lvl_r <= LVL_RESET;
        end else begin
            lvl_r <= lvl_nxt;
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            lock_r <= LOCK_RESET;
        end else begin
            lock_r <= lock_nxt;
        end
    end

    // one-cycle answers to a request
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            start_r <= 1'h0;
        end else begin
            start_r <= op_take;
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            refused_r <= 1'h0;
        end else begin
            refused_r <= op_bad;
        end
    end

    // status byte built bit by bit from the field positions
    logic [STAT_W-1:0] stat_bits;
    genvar b;
    generate
        for (b = 0; b < STAT_W; b = b + 1) begin : g_stat
            if (b == BUSY_POS) begin : g_busy
                assign stat_bits[b] = is_busy;
            end else if (b == WEL_POS) begin : g_wel
                assign stat_bits[b] = wel_r;
            end else if (b >= LVL_LO_POS && b <= LVL_HI_POS) begin : g_lvl
                assign stat_bits[b] = lvl_r[b - LVL_LO_POS];
            end else if (b == LOCK_POS) begin : g_lock
                assign stat_bits[b] = lock_r;
            end else begin : g_rsvd
                assign stat_bits[b] = 1'h0;
            end
        end
    endgenerate

    assign o_op_start = start_r;
    assign o_op_refused = refused_r;
    assign o_status = stat_bits;
endmodule

/* tb/fsbp_asserts.sv */
`timescale 1ns/1ps
module fsbp_asserts (
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic I_WP_N,
    input wire logic i_write_disable_cmd,
    input wire logic i_status_write_cmd,
    input wire logic i_op_req,
    input wire logic [1:0] i_op_code,
    input wire logic i_op_done,
    input wire logic o_op_start,
    input wire logic o_op_refused,
    input wire logic [7:0] o_status
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    wire [7:0] s = o_status;
    wire take = i_op_req && !s[0];
    a_reserved_zero: assert property (s[6:5] == 2'h0) else $error("reserved");
    a_start_busy: assert property (o_op_start |-> s[0] && !o_op_refused) else $error("busy");
    a_no_latch: assert property (take && !s[1] |=> o_op_refused) else $error("latch");
    a_chip_level: assert property (take && i_op_code == 2'h3 && s[4:2] != 3'h0 |=> o_op_refused)
        else $error("chip");
    a_all_protect: assert property (take && s[4:2] == 3'h7 |=> o_op_refused) else $error("range");
    a_done_clear: assert property (s[0] && i_op_done |=> s[1:0] == 2'h0) else $error("done");
    a_write_clear: assert property (!s[0] && (i_status_write_cmd || i_write_disable_cmd) |=> !s[1])
        else $error("wel");
    a_lock_hold: assert property ((s[7] && !I_WP_N) [*3] |=> $stable(s[7:2])) else $error("lock");
    c_start: cover property (o_op_start);
    c_refuse: cover property (o_op_refused);
    c_locked: cover property (s[7] && !I_WP_N);
endmodule
bind fsbp_status fsbp_asserts i_fsbp_asserts (
    .I_CLOCK(I_CLOCK),
    .I_RST(I_RST),
    .I_WP_N(I_WP_N),
    .i_write_disable_cmd(i_write_disable_cmd),
    .i_status_write_cmd(i_status_write_cmd),
    .i_op_req(i_op_req),
    .i_op_code(i_op_code),
    .i_op_done(i_op_done),
    .o_op_start(o_op_start),
    .o_op_refused(o_op_refused),
    .o_status(o_status)
);

/* tb/fsbp_host.sv */
`timescale 1ns/1ps
module fsbp_host (
    input wire logic i_clk,
    input wire logic i_start,
    output logic [3:0] o_cmd = 4'h0,
    output logic o_done = 1'h0,
    output logic [1:0] o_code = 2'h0,
    output logic [23:0] o_addr = 24'h0,
    output logic [7:0] o_wdata = 8'h0
);
    // one-cycle command, then released lines scrambled
    task automatic send(input int k, input logic [7:0] d, input logic [1:0] c, input logic [23:0] a);
        @(negedge i_clk);
        o_cmd = 4'h1 << k;
        o_wdata = d;
        o_code = c;
        o_addr = a;
        @(negedge i_clk);
        o_cmd = 4'h0;
        o_wdata = ~d;
        o_code = ~c;
        o_addr = ~a;
    endtask
    // array finishes five cycles after a start
    always @(negedge i_clk) if (i_start) begin
        repeat (5) @(negedge i_clk);
        o_done = 1'h1;
        @(negedge i_clk);
        o_done = 1'h0;
    end
endmodule

/* tb/flash_status_block_protect_bench.sv */
`timescale 1ns/1ps
module flash_status_block_protect_bench;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic wp_n = 1'h1;
    logic start, refd, done;
    logic [3:0] cmd;
    logic [1:0] code;
    logic [23:0] addr;
    logic [7:0] wd, st;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    initial forever #5 clk = ~clk;
    fsbp_status i_fsbp_status (.I_CLOCK(clk), .I_RST(rst), .I_WP_N(wp_n), .i_write_enable_cmd(cmd[3]),
        .i_write_disable_cmd(cmd[2]), .i_status_write_cmd(cmd[1]), .i_status_wdata(wd), .i_op_req(cmd[0]),
        .i_op_code(code), .i_op_addr(addr), .i_op_done(done), .o_op_start(start), .o_op_refused(refd),
        .o_status(st));
    fsbp_host i_fsbp_host (.i_clk(clk), .i_start(start), .o_cmd(cmd), .o_done(done), .o_code(code),
        .o_addr(addr), .o_wdata(wd));
    task automatic tx(int k, logic [7:0] d = 8'h0, logic [1:0] c = 2'h0, logic [23:0] a = 24'h0);
        i_fsbp_host.send(k, d, c, a);
    endtask
    task automatic chk(input logic [9:0] e);
        checked++;
        if ({start, refd, st} !== e) begin
            err_total++;
            $display("Error %0t: got %h want %h", $time, {start, refd, st}, e);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'h0;
        chk(10'h01C);
        tx(0);
        chk(10'h11C);
        tx(3);
        chk(10'h01E);
        tx(1, 8'hFF);
        chk(10'h09C);
        wp_n = 1'h0;
        tx(3);
        tx(1);
        chk(10'h09C);
        wp_n = 1'h1;
        tx(3);
        tx(1);
        chk(10'h000);
        $display("lock tests done");
        for (int l = 1; l < 7; l++) begin
            tx(3);
            tx(1, 8'(l << 2));
            tx(3);
            tx(0, 0, 2'(l % 3), {2'h0, 6'(64 - (1 << (l - 1))), 16'h0});
            chk(10'h102 | 10'(l << 2));
            tx(3);
            tx(0, 0, 2'(l % 3), {2'h0, 6'(63 - (1 << (l - 1))), 16'hFFFF});
            chk(10'h203 | 10'(l << 2));
            for (int n = 0; n < 20 && st[0] !== 1'h0; n++) @(negedge clk);
            chk(10'(l << 2));
        end
        tx(3);
        tx(0, 0, 2'h3);
        chk(10'h11A);
        tx(3);
        tx(1);
        tx(3);
        tx(0, 0, 2'h3);
        chk(10'h203);
        for (int n = 0; n < 20 && st[0] !== 1'h0; n++) @(negedge clk);
        tx(3);
        tx(2);
        chk(10'h000);
        tx(3);
        tx(1, 8'h1C);
        tx(3);
        tx(0);
        chk(10'h11E);
        $display("level tests done");
        report_and_stop();
    end
endmodule
